// file: src/ssl_shift_latch.sv
// Serial-to-parallel shift latch: shift stages, storage register and gated parallel outputs.
// Assumes the controller's clocks, data, clear and enable are asynchronous pins sampled here.
`timescale 1ns/1ps
module ssl_shift_latch
  import ssl_pkg::*;
#(
  parameter int WIDTH = SSL_WIDTH
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic serial_data_in,
  input wire logic shift_clock_in,
  input wire logic storage_clock_in,
  input wire logic shift_clear_n,
  input wire logic output_enable_n,
  output logic serial_cascade_out,
  output logic [WIDTH-1:0] parallel_data_out,
  output logic [WIDTH-1:0] parallel_data_oe
);
  initial begin
    if (WIDTH < 2) $error("ssl_shift_latch: WIDTH must be at least 2");
  end

  // Rising edge of a synchronised pin against its value one cycle earlier
  function automatic logic edge_rise(input logic now_v, input logic prev_v);
    return now_v & ~prev_v;
  endfunction : edge_rise

  // Pins in order: shift clock, storage clock, clear
  logic [2:0] ctl_sync;
  logic data_meta_reg;
  logic data_sync_reg;
  logic oe_meta_reg;
  logic oe_sync_reg;
  logic shift_clk_prev_reg;
  logic store_clk_prev_reg;
  logic [WIDTH-1:0] stage_reg;
  logic [WIDTH-1:0] stage_next;
  logic [WIDTH-1:0] store_reg;
  logic [WIDTH-1:0] store_next;

  ssl_pin_sync #(
    .WIDTH(3)
  ) u_ctl_sync (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .pin_async({shift_clock_in, storage_clock_in, shift_clear_n}),
    .pin_sync(ctl_sync)
  );

  wire shift_clk_s = ctl_sync[2];
  wire store_clk_s = ctl_sync[1];
  wire clear_s_n = ctl_sync[0];
  wire shift_rise = edge_rise(shift_clk_s, shift_clk_prev_reg);
  wire store_rise = edge_rise(store_clk_s, store_clk_prev_reg);
  wire stage_six_value = stage_reg[WIDTH-2];

  // Each stage takes the one below it; stage 0 takes the serial data
  wire [WIDTH-1:0] shifted_vec;
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_stage
      if (gi == 0) begin : g_first
        assign shifted_vec[gi] = data_sync_reg;
      end else begin : g_chain
        assign shifted_vec[gi] = stage_reg[gi-1];
      end
    end
  endgenerate

  // Data passes the same two flops as the clocks, so the level at the shift edge is taken
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      data_meta_reg <= 1'b0;
      data_sync_reg <= 1'b0;
      oe_meta_reg <= 1'b1;
      oe_sync_reg <= 1'b1;
      shift_clk_prev_reg <= 1'b0;
      store_clk_prev_reg <= 1'b0;
    end else begin
      data_meta_reg <= serial_data_in;
      data_sync_reg <= data_meta_reg;
      oe_meta_reg <= output_enable_n;
      oe_sync_reg <= oe_meta_reg;
      shift_clk_prev_reg <= shift_clk_s;
      store_clk_prev_reg <= store_clk_s;
    end
  end

  // Shift stages: clear dominates, otherwise advance on a shift edge
  always_comb begin
    if (!clear_s_n) begin
      stage_next = WIDTH'(SSL_SHIFT_RESET);
    end else if (shift_rise) begin
      stage_next = shifted_vec;
    end else begin
      stage_next = stage_reg;
    end
  end

  // Storage takes the stages as they stand before this cycle's shift, or SSL_STORE_RESET while clear is low
  always_comb begin
    if (store_rise) begin
      store_next = clear_s_n ? stage_reg : WIDTH'(SSL_STORE_RESET);
    end else begin
      store_next = store_reg;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      stage_reg <= SSL_SHIFT_RESET;
      store_reg <= SSL_STORE_RESET;
    end else begin
      stage_reg <= stage_next;
      store_reg <= store_next;
    end
  end

  assign serial_cascade_out = stage_reg[WIDTH-1];
  assign parallel_data_out = store_reg;
  assign parallel_data_oe = {WIDTH{~oe_sync_reg}};

  AST_SHIFT_MOVES: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (shift_rise && clear_s_n) |=> stage_reg == {$past(stage_reg[WIDTH-2:0]), $past(data_sync_reg)})
    else $error("shift stages did not advance with serial data");

  AST_NO_EDGE_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!shift_rise && clear_s_n) |=> $stable(stage_reg))
    else $error("shift stages moved without a shift edge");

  AST_CASCADE_STAGE6: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (shift_rise && clear_s_n) |=> serial_cascade_out == $past(stage_six_value))
    else $error("cascade output did not take stage six");

  AST_STORE_COPY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (store_rise && clear_s_n) |=> parallel_data_out == $past(stage_reg))
    else $error("storage did not copy pre-shift stages");

  AST_STORE_ONLY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (store_rise && !shift_rise && clear_s_n) |=> $stable(serial_cascade_out))
    else $error("cascade changed on a storage-only edge");

  sequence s_both_edges;
    store_rise && shift_rise && clear_s_n;
  endsequence
  AST_TIED_LAG: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_both_edges |=> parallel_data_out == {$past(stage_reg)} &&
    stage_reg == {$past(stage_reg[WIDTH-2:0]), $past(data_sync_reg)})
    else $error("storage did not lag shift register by one pulse");

  AST_CLEAR_ZERO: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !clear_s_n |=> stage_reg == '0 && !serial_cascade_out)
    else $error("clear did not zero the shift stages");

  AST_CLEAR_HOLD: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!clear_s_n && !store_rise) |=> $stable(parallel_data_out))
    else $error("storage changed during clear without a storage edge");

  AST_CLEAR_STORE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!clear_s_n && store_rise) |=> parallel_data_out == '0)
    else $error("storage edge during clear did not load zeros");

  AST_OE_FOLLOW: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $fell(oe_meta_reg) |=> parallel_data_oe == '1)
    else $error("outputs not enabled after enable went low");

  AST_OE_FLOAT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    oe_sync_reg |-> parallel_data_oe == '0)
    else $error("outputs driven while enable high");

  AST_OE_ENABLED: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !oe_sync_reg |-> parallel_data_oe == '1)
    else $error("outputs not driven while enable low");

  AST_OE_RELEASE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    $rose(oe_meta_reg) |=> parallel_data_oe == '0)
    else $error("outputs still driven after enable went high");

  sequence s_oe_toggle_quiet;
    $changed(oe_sync_reg) && !store_rise && !shift_rise && clear_s_n;
  endsequence
  AST_OE_NO_EFFECT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    s_oe_toggle_quiet |=> $stable(parallel_data_out) && $stable(serial_cascade_out))
    else $error("enable change disturbed storage or cascade");

  AST_STORE_NEEDS_EDGE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    !store_rise |=> $stable(parallel_data_out))
    else $error("storage changed without a storage edge");

  AST_SHIFT_SINGLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    shift_rise |=> !shift_rise)
    else $error("one shift clock rise seen as two edges");

  AST_STORE_SINGLE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    store_rise |=> !store_rise)
    else $error("one storage clock rise seen as two edges");

  AST_CLEAR_BLOCKS_SHIFT: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (!clear_s_n && shift_rise && !store_rise) |=> stage_reg == '0 && $stable(parallel_data_out))
    else $error("shift edge during clear moved stages or storage");

  AST_PAR7_CASCADE: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (store_rise && clear_s_n) |=> parallel_data_out[WIDTH-1] == $past(serial_cascade_out))
    else $error("top parallel bit differs from cascade stage");

  AST_DATA_ENTRY: assert property (@(posedge clk_sys) disable iff (sys_rst)
    (shift_rise && clear_s_n) |=> stage_reg[0] == $past(data_sync_reg))
    else $error("serial data did not enter stage zero");
endmodule : ssl_shift_latch

// file: src/ssl_pkg.sv
// Package for the serial-to-parallel shift latch: widths, stage indices and reset values.
// Assumes the latch is clocked by a 10 MHz system clock that samples the controller pins.
package ssl_pkg;
  localparam int SSL_WIDTH = 8;
  localparam int SSL_LAST_STAGE = SSL_WIDTH - 1;
  localparam int SSL_SYNC_DEPTH = 2;
  localparam logic [SSL_WIDTH-1:0] SSL_SHIFT_RESET = 8'h00;
  localparam logic [SSL_WIDTH-1:0] SSL_STORE_RESET = 8'h00;
  localparam logic [2:0] SSL_PIN_RESET = 3'h0;
endpackage : ssl_pkg

// file: src/ssl_pin_sync.sv
// Two-flop synchroniser bank for pins arriving from outside the system clock domain.
// Assumes every pin is a slow level relative to clk_sys.
`timescale 1ns/1ps
module ssl_pin_sync
  import ssl_pkg::*;
#(
  parameter int WIDTH = 3
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_sync
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] sync_reg;

  initial begin
    if (WIDTH < 1) $error("ssl_pin_sync: WIDTH must be at least 1");
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= pin_async;
      sync_reg <= meta_reg;
    end
  end

  assign pin_sync = sync_reg;
endmodule : ssl_pin_sync

// file: verification/ssl_host_model.sv
// Host controller model: drives serial data, shift clock, storage clock and clear.
// Assumes clk_sys paces it; one clock pulse spans 8 system cycles, 800 ns.
`timescale 1ns/1ps
module ssl_host_model (
  input wire logic clk_sys,
  output logic serial_data_in,
  output logic shift_clock_in,
  output logic storage_clock_in,
  output logic shift_clear_n
);
  initial begin
    serial_data_in = 1'b0;
    shift_clock_in = 1'b0;
    storage_clock_in = 1'b0;
    shift_clear_n = 1'b1;
  end
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : wait_cyc
  // Data settles two cycles before the rise and holds through the high phase
  task automatic pulse(input logic sh, input logic st, input logic d);
    serial_data_in = d;
    wait_cyc(2);
    shift_clock_in = sh;
    storage_clock_in = st;
    wait_cyc(4);
    shift_clock_in = 1'b0;
    storage_clock_in = 1'b0;
    wait_cyc(1);
    serial_data_in = ~d;
    wait_cyc(1);
  endtask : pulse
  task automatic set_clear(input logic v);
    shift_clear_n = v;
    wait_cyc(4);
  endtask : set_clear
endmodule : ssl_host_model

// file: verification/ssl_shift_latch_tb_top.sv
// Testbench for the shift latch: queued expectations checked by a monitor process.
// Assumes the host model paces clock pulses from clk_sys.
`timescale 1ns/1ps
module ssl_shift_latch_tb_top;
  import ssl_pkg::*;
  logic clk_sys, sys_rst, output_enable_n, serial_cascade_out, clr;
  logic serial_data_in, shift_clock_in, storage_clock_in, shift_clear_n;
  logic [7:0] parallel_data_out, parallel_data_oe, sr, st, b;
  logic [16:0] q[$];
  logic [16:0] seen_w;
  int mismatches = 0;
  int n_checks = 0;
  int seed = 32'h1e55;
  ssl_host_model host (.clk_sys(clk_sys), .serial_data_in(serial_data_in),
    .shift_clock_in(shift_clock_in), .storage_clock_in(storage_clock_in),
    .shift_clear_n(shift_clear_n));
  ssl_shift_latch dut (.clk_sys(clk_sys), .sys_rst(sys_rst), .serial_data_in(serial_data_in),
    .shift_clock_in(shift_clock_in), .storage_clock_in(storage_clock_in),
    .shift_clear_n(shift_clear_n), .output_enable_n(output_enable_n),
    .serial_cascade_out(serial_cascade_out), .parallel_data_out(parallel_data_out),
    .parallel_data_oe(parallel_data_oe));
  assign seen_w = {serial_cascade_out, parallel_data_oe, parallel_data_out};
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  task automatic note;
    q.push_back({sr[7], {8{~output_enable_n}}, st});
  endtask : note
  // Mirror of the stages and storage, then one host pulse
  task automatic op(input logic s, input logic t, input logic d);
    if (t) st = sr;
    if (s && clr) sr = {sr[6:0], d};
    host.pulse(s, t, d);
  endtask : op
  always @(posedge clk_sys) begin
    if (q.size() > 0) begin
      check("cascade_oe_parallel", seen_w, q.pop_front());
    end
  end
  initial begin
    repeat (3000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    output_enable_n = 1'b1;
    sr = 8'h00;
    st = 8'h00;
    clr = 1'b1;
    host.wait_cyc(10);
    sys_rst = 1'b0;
    host.wait_cyc(3);
    note();
    output_enable_n = 1'b0;
    host.wait_cyc(4);
    note();
    repeat (4) begin
      output_enable_n = 1'($random(seed));
      b = 8'($random(seed));
      for (int i = 7; i >= 0; i--) op(1'b1, 1'b0, b[i]);
      note();
      op(1'b0, 1'b1, 1'b0);
      note();
    end
    op(1'b1, 1'b1, 1'($random(seed)));
    note();
    op(1'b1, 1'b0, 1'($random(seed)));
    note();
    host.set_clear(1'b0);
    clr = 1'b0;
    sr = 8'h00;
    note();
    op(1'b1, 1'b0, 1'b1);
    note();
    op(1'b0, 1'b1, 1'b0);
    note();
    host.set_clear(1'b1);
    clr = 1'b1;
    output_enable_n = 1'b1;
    host.wait_cyc(4);
    note();
    b = 8'($random(seed));
    for (int i = 7; i >= 0; i--) op(1'b1, 1'b0, b[i]);
    op(1'b0, 1'b1, 1'b0);
    note();
    host.wait_cyc(3);
    wrap_up();
  end
endmodule : ssl_shift_latch_tb_top
